/* hw/rhg_params.svh */
// Purpose: constants for the random source health gate
// Assumes: 10 MHz clk, raw bits arrive as a level from the analog source
// Notes:   counts are in raw bits, except RHG_SAMPLE_DIV in clk cycles
`ifndef RHG_PARAMS_SVH
`define RHG_PARAMS_SVH

`define RHG_WORD_W        16
`define RHG_SAMPLE_DIV    4'hA
`define RHG_STUCK_LIMIT   8'h40
`define RHG_WIN_LEN       12'h400
`define RHG_ONES_LO       12'h1A0
`define RHG_ONES_HI       12'h260
`define RHG_BYTE_BITS     5'h08
`define RHG_HALF_BITS     5'h10

`endif

/* hw/rhg_pkg.sv */
// Purpose: types for the random source health gate
// Assumes: nothing
// Notes:   one-hot state codes
package rhg_pkg;
  typedef enum logic [2:0] {
    RHG_STARTUP = 3'h1,
    RHG_RUN     = 3'h2,
    RHG_FAIL    = 3'h4
  } rhg_state_e;
endpackage

/* hw/rhg_bit_sampler.sv */
// Purpose: synchronise the raw bit and pulse once per sample period
// Assumes: raw bit is asynchronous to clk
// Notes:   first flop read only by the second
`timescale 1ns/1ps
`default_nettype none
`include "rhg_params.svh"
module rhg_bit_sampler (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw source
  input  wire logic rawBitIn,
  // sampled bit
  output logic      sampleBit,
  output logic      sampleStrobe
);
  logic       syncA;
  logic       syncB;
  logic [3:0] divCount;
  logic [3:0] next_divCount;
  logic       next_sampleBit;
  logic       next_sampleStrobe;

  // ----------------------------------------
  // divider for sample enable
  // ----------------------------------------
  always_comb begin
    next_sampleStrobe = 1'b0;
    next_sampleBit    = sampleBit;
    next_divCount     = divCount + 4'h1;
    if (divCount == `RHG_SAMPLE_DIV - 4'h1) begin
      next_divCount     = 4'h0;
      next_sampleStrobe = 1'b1;
      next_sampleBit    = syncB;
    end
  end

  // two-flop synchroniser and registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA        <= 1'b0;
      syncB        <= 1'b0;
      divCount     <= 4'h0;
      sampleBit    <= 1'b0;
      sampleStrobe <= 1'b0;
    end else begin
      syncA        <= rawBitIn;
      syncB        <= syncA;
      divCount     <= next_divCount;
      sampleBit    <= next_sampleBit;
      sampleStrobe <= next_sampleStrobe;
    end
  end
endmodule
`default_nettype wire

/* hw/rhg_health_gate.sv */
// Purpose: health tests on raw random bits and gated word delivery
// Assumes: consumer takes a word in the cycle wordValid is high
// Notes:   failures are sticky until rst_n
//
// How it works
// R1 - startup window checks for dead source first
// R2 - total failure blocks every later word
// R3 - words holding post-failure bits are dropped
// R4 - online ones-count test at startup and always
// R5 - no output until startup window passes
// R6 - test runs continuously without any request
// R7 - words are 8 or 16 bits wide
// R8 - entropy bound checked by the ones-count window limits
// R9 - repeated consecutive words raise failure
// R10 - failures latch as readable sticky flags
// R11 - valid low whenever any test fails
`timescale 1ns/1ps
`default_nettype none
`include "rhg_params.svh"
module rhg_health_gate (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // entropy source
  input  wire logic                   rawBitIn,
  // configuration
  input  wire logic                   wideMode,
  // output words
  output logic [`RHG_WORD_W-1:0]      wordData,
  output logic                        wordValid,
  // status
  output logic                        startupDone,
  output logic                        totalFailFlag,
  output logic                        onlineFailFlag,
  output logic                        repeatFailFlag
);
  logic                   sampleBit;
  logic                   sampleStrobe;
  rhg_pkg::rhg_state_e    state;
  rhg_pkg::rhg_state_e    next_state;
  logic                   lastBit;
  logic                   next_lastBit;
  logic [7:0]             runLen;
  logic [7:0]             next_runLen;
  logic [11:0]            winCount;
  logic [11:0]            next_winCount;
  logic [11:0]            onesCount;
  logic [11:0]            next_onesCount;
  logic [11:0]            onesTotal;
  logic [`RHG_WORD_W-1:0] shiftReg;
  logic [`RHG_WORD_W-1:0] next_shiftReg;
  logic [4:0]             bitCount;
  logic [4:0]             next_bitCount;
  logic [`RHG_WORD_W-1:0] prevWord;
  logic [`RHG_WORD_W-1:0] next_prevWord;
  logic                   havePrev;
  logic                   next_havePrev;
  logic [`RHG_WORD_W-1:0] next_wordData;
  logic                   next_wordValid;
  logic                   next_startupDone;
  logic                   next_totalFail;
  logic                   next_onlineFail;
  logic                   next_repeatFail;
  logic                   stuckHit;
  logic                   winEnd;
  logic                   winBad;
  logic                   wordDone;
  logic [`RHG_WORD_W-1:0] newWord;
  logic                   anyFail;

  // mask a word to its active width
  function automatic logic [`RHG_WORD_W-1:0] fit_word(
    input logic [`RHG_WORD_W-1:0] w,
    input logic                   wide
  );
    fit_word = wide ? w : {8'h00, w[7:0]};
  endfunction

  // sampler instance
  rhg_bit_sampler uSampler (
    .clk          (clk),
    .rst_n        (rst_n),
    .rawBitIn     (rawBitIn),
    .sampleBit    (sampleBit),
    .sampleStrobe (sampleStrobe)
  );

  // ----------------------------------------
  // health test decodes
  // ----------------------------------------
  assign stuckHit = sampleStrobe && (sampleBit == lastBit)
                    && (runLen == `RHG_STUCK_LIMIT - 8'h01);   // see R1
  assign winEnd   = sampleStrobe && (winCount == `RHG_WIN_LEN - 12'h001); // see R6
  // window total including this sample, independent of the wrap below
  assign onesTotal = onesCount + {11'h000, sampleBit};                  // see R6
  assign winBad   = (onesTotal < `RHG_ONES_LO) || (onesTotal > `RHG_ONES_HI); // see R4, see R8
  assign newWord  = fit_word({shiftReg[`RHG_WORD_W-2:0], sampleBit}, wideMode); // see R7
  assign wordDone = sampleStrobe
                    && (bitCount == (wideMode ? `RHG_HALF_BITS : `RHG_BYTE_BITS) - 5'h01);
  assign anyFail  = totalFailFlag || onlineFailFlag || repeatFailFlag;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    next_state       = state;
    next_lastBit     = lastBit;
    next_runLen      = runLen;
    next_winCount    = winCount;
    next_onesCount   = onesCount;
    next_shiftReg    = shiftReg;
    next_bitCount    = bitCount;
    next_prevWord    = prevWord;
    next_havePrev    = havePrev;
    next_wordData    = wordData;
    next_wordValid   = 1'b0;
    next_startupDone = startupDone;
    next_totalFail   = totalFailFlag;
    next_onlineFail  = onlineFailFlag;
    next_repeatFail  = repeatFailFlag;
    if (sampleStrobe) begin
      // run length for stuck-at detection
      next_lastBit  = sampleBit;
      next_runLen   = (sampleBit == lastBit) ? runLen + 8'h01 : 8'h00;
      // ones count over a fixed window, always running
      next_onesCount = onesTotal;                  // see R6
      next_winCount  = winCount + 12'h001;
      next_shiftReg  = {shiftReg[`RHG_WORD_W-2:0], sampleBit};
      next_bitCount  = bitCount + 5'h01;
    end
    if (winEnd) begin
      next_winCount  = 12'h000;
      next_onesCount = 12'h000;
      if (winBad) begin
        next_onlineFail = 1'b1;                    // see R4, see R10
      end else if (state == rhg_pkg::RHG_STARTUP) begin
        next_startupDone = 1'b1;                   // see R5
      end
    end
    if (stuckHit) begin
      next_totalFail = 1'b1;                       // see R1, see R10
    end
    if (wordDone) begin
      next_bitCount = 5'h00;
      next_prevWord = newWord;
      next_havePrev = 1'b1;
      if (havePrev && newWord == prevWord) begin
        next_repeatFail = 1'b1;                    // see R9, see R10
      end
      // deliver only if no failure now or in this very sample
      if (state == rhg_pkg::RHG_RUN && !anyFail && !stuckHit
          && !(winEnd && winBad) && !(havePrev && newWord == prevWord)) begin
        next_wordData  = newWord;                  // see R3, see R11
        next_wordValid = 1'b1;
      end
    end
    case (state)
      rhg_pkg::RHG_STARTUP: begin
        if (next_totalFail || next_onlineFail) begin
          next_state = rhg_pkg::RHG_FAIL;
        end else if (next_startupDone) begin
          next_state    = rhg_pkg::RHG_RUN;        // see R5
          next_bitCount = 5'h00;
          next_havePrev = 1'b0;
        end
      end
      rhg_pkg::RHG_RUN: begin
        if (next_totalFail || next_onlineFail || next_repeatFail) begin
          next_state = rhg_pkg::RHG_FAIL;          // see R2
        end
      end
      rhg_pkg::RHG_FAIL: begin
        next_wordValid = 1'b0;                     // see R2
      end
      default: begin
        next_state = rhg_pkg::RHG_FAIL;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= rhg_pkg::RHG_STARTUP;
      lastBit        <= 1'b0;
      runLen         <= 8'h00;
      winCount       <= 12'h000;
      onesCount      <= 12'h000;
      shiftReg       <= '0;
      bitCount       <= 5'h00;
      prevWord       <= '0;
      havePrev       <= 1'b0;
      wordData       <= '0;
      wordValid      <= 1'b0;
      startupDone    <= 1'b0;
      totalFailFlag  <= 1'b0;
      onlineFailFlag <= 1'b0;
      repeatFailFlag <= 1'b0;
    end else begin
      state          <= next_state;
      lastBit        <= next_lastBit;
      runLen         <= next_runLen;
      winCount       <= next_winCount;
      onesCount      <= next_onesCount;
      shiftReg       <= next_shiftReg;
      bitCount       <= next_bitCount;
      prevWord       <= next_prevWord;
      havePrev       <= next_havePrev;
      wordData       <= next_wordData;
      wordValid      <= next_wordValid;
      startupDone    <= next_startupDone;
      totalFailFlag  <= next_totalFail;
      onlineFailFlag <= next_onlineFail;
      repeatFailFlag <= next_repeatFail;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_stuck;
    stuckHit;
  endsequence
  sequence s_flagged;
    ##1 totalFailFlag;
  endsequence

  property p_stuck_flag;
    @(posedge clk) disable iff (!rst_n) s_stuck |-> s_flagged;
  endproperty
  a_stuck_flag: assert property (p_stuck_flag) else $error("stuck source not flagged"); // see R1

  property p_no_word_after_total;
    @(posedge clk) disable iff (!rst_n) totalFailFlag |-> !wordValid;
  endproperty
  a_no_word_after_total: assert property (p_no_word_after_total) else $error("word after total fail"); // see R2

  property p_stuck_word_dropped;
    @(posedge clk) disable iff (!rst_n) stuckHit |=> !wordValid;
  endproperty
  a_stuck_word_dropped: assert property (p_stuck_word_dropped) else $error("post-fail word out"); // see R3

  property p_online_flag;
    @(posedge clk) disable iff (!rst_n) (winEnd && winBad) |=> onlineFailFlag;
  endproperty
  a_online_flag: assert property (p_online_flag) else $error("online defect missed"); // see R4

  property p_no_word_before_startup;
    @(posedge clk) disable iff (!rst_n) !startupDone |-> !wordValid;
  endproperty
  a_no_word_before_startup: assert property (p_no_word_before_startup) else $error("early word"); // see R5

  property p_window_wraps;
    @(posedge clk) disable iff (!rst_n) winEnd |=> (winCount == 12'h000);
  endproperty
  a_window_wraps: assert property (p_window_wraps) else $error("window did not restart"); // see R6

  property p_narrow_word;
    @(posedge clk) disable iff (!rst_n) (wordValid && !wideMode && $stable(wideMode))
      |-> (wordData[15:8] == 8'h00);
  endproperty
  a_narrow_word: assert property (p_narrow_word) else $error("byte word has upper bits"); // see R7

  property p_repeat_flag;
    @(posedge clk) disable iff (!rst_n) (wordDone && havePrev && newWord == prevWord)
      |=> repeatFailFlag ##1 !wordValid;
  endproperty
  a_repeat_flag: assert property (p_repeat_flag) else $error("repeat not caught"); // see R9

  property p_sticky;
    @(posedge clk) disable iff (!rst_n) $rose(onlineFailFlag) |=> onlineFailFlag [*8];
  endproperty
  a_sticky: assert property (p_sticky) else $error("fail flag cleared"); // see R10

  property p_valid_gated;
    @(posedge clk) disable iff (!rst_n) wordValid |-> (state == rhg_pkg::RHG_RUN && !anyFail);
  endproperty
  a_valid_gated: assert property (p_valid_gated) else $error("valid while failing"); // see R11
endmodule
`default_nettype wire

/* tb/rhg_word_sink.sv */
// Purpose: consumer model that takes random words from the gate
// Assumes: a word is taken only in the cycle wordValid is high
// Notes:   tallies words, words before startup and repeated words
`timescale 1ns/1ps
`default_nettype none
`include "rhg_params.svh"
module rhg_word_sink (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // word stream
  input  wire logic [`RHG_WORD_W-1:0] wordData,
  input  wire logic                   wordValid,
  input  wire logic                   startupDone,
  // tallies
  output logic [15:0]                 wordCount,
  output logic [15:0]                 earlyCount,
  output logic [15:0]                 repeatCount
);
  logic [`RHG_WORD_W-1:0] lastWord;
  logic                   haveWord;

  // take a word only while valid is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wordCount   <= 16'h0000;
      earlyCount  <= 16'h0000;
      repeatCount <= 16'h0000;
      lastWord    <= '0;
      haveWord    <= 1'b0;
    end else if (wordValid) begin
      wordCount <= wordCount + 16'h0001;
      lastWord  <= wordData;
      haveWord  <= 1'b1;
      if (!startupDone) begin
        earlyCount <= earlyCount + 16'h0001;
      end
      if (haveWord && wordData == lastWord) begin
        repeatCount <= repeatCount + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/rhg_health_gate_tb_top.sv */
// Purpose: self-checking bench for the random source health gate
// Assumes: one raw bit held for ten clocks, pattern picked per test
// Notes:   every wait is bounded; run ends in give_verdict
`timescale 1ns/1ps
`default_nettype none
`include "rhg_params.svh"
module rhg_health_gate_tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   rawBitIn;
  logic                   wideMode = 1'b0;
  logic [`RHG_WORD_W-1:0] wordData;
  logic                   wordValid;
  logic                   startupDone;
  logic                   totalFailFlag;
  logic                   onlineFailFlag;
  logic                   repeatFailFlag;
  logic [15:0]            wordCount;
  logic [15:0]            earlyCount;
  logic [15:0]            repeatCount;
  logic [1:0]             srcMode = 2'h0;
  logic [3:0]             divCnt = 4'h0;
  logic [2:0]             bitIdx = 3'h0;
  logic [7:0]             srcByte = 8'h00;
  logic [7:0]             curByte;
  logic [4:0]             evts;
  int                     mismatches = 0;
  int                     numChecks = 0;

  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  rhg_health_gate rhg_health_gate_inst (
    .clk(clk), .rst_n(rst_n), .rawBitIn(rawBitIn), .wideMode(wideMode),
    .wordData(wordData), .wordValid(wordValid), .startupDone(startupDone),
    .totalFailFlag(totalFailFlag), .onlineFailFlag(onlineFailFlag),
    .repeatFailFlag(repeatFailFlag));

  rhg_word_sink rhg_word_sink_inst (
    .clk(clk), .rst_n(rst_n), .wordData(wordData), .wordValid(wordValid),
    .startupDone(startupDone), .wordCount(wordCount),
    .earlyCount(earlyCount), .repeatCount(repeatCount));

  // raw bit source, each bit held ten clocks so each is sampled once
  always @(negedge clk) begin
    if (divCnt == 4'h9) begin
      divCnt <= 4'h0;
      bitIdx <= bitIdx + 3'h1;
      if (bitIdx == 3'h7) begin
        srcByte <= srcByte + 8'h01;
      end
    end else begin
      divCnt <= divCnt + 4'h1;
    end
  end
  // mode 0 counter, 1 stuck low, 2 ones-biased counter, 3 periodic byte
  assign curByte  = (srcMode == 2'h2) ? (srcByte | 8'hF0) :
                    ((srcMode == 2'h3) ? 8'h5A : srcByte);
  assign rawBitIn = (srcMode != 2'h1) & curByte[3'h7 - bitIdx];
  assign evts     = {repeatFailFlag, onlineFailFlag, totalFailFlag, wordValid, startupDone};

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] mode, input logic wide);
    @(negedge clk);
    rst_n    = 1'b0;
    srcMode  = mode;
    wideMode = wide;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
  endtask

  // wait for evts[which], n counts the edges waited
  task automatic wait_on(input int which, input int bound, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (evts[which] !== 1'b1 && n < bound);
    if (evts[which] !== 1'b1) begin
      chk(evts[which], 1'b1);
      give_verdict;
    end
  endtask

  task automatic hold_no_words(input logic [1:0] mode);
    logic [15:0] wc;
    wc = wordCount;
    @(negedge clk);
    srcMode = mode;
    repeat (300) @(posedge clk);
    #1;
    chk(wordCount, wc);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_startup(input logic [1:0] mode);
    int n;
    do_reset(mode, 1'b0);
    @(posedge clk);
    #1;
    chk({wordData, evts}, 21'h0);
    wait_on(mode == 2'h2 ? 3 : 0, 11000, n);
    chk(startupDone, mode != 2'h2);
    chk(earlyCount, 16'h0000);
    chk(wordCount, 16'h0000);
    chk(totalFailFlag, 1'b0);
    $display("test startup end");
  endtask

  task automatic t_words8;
    int n;
    wait_on(1, 200, n);
    repeat (3) begin
      wait_on(1, 200, n);
      chk(n, 80);
      chk(wordData[15:8], 8'h00);
    end
    $display("test words8 end");
  endtask

  task automatic t_words16;
    int n;
    wait_on(1, 200, n);
    @(negedge clk);
    wideMode = 1'b1;
    repeat (2) begin
      wait_on(1, 400, n);
      chk(n, 160);
    end
    chk(repeatCount, 16'h0000);
    $display("test words16 end");
  endtask

  task automatic t_stuck;
    int n;
    @(negedge clk);
    srcMode = 2'h1;
    wait_on(2, 800, n);
    chk(n <= 680, 1'b1);
    hold_no_words(2'h0);
    chk(totalFailFlag, 1'b1);
    $display("test stuck end");
  endtask

  task automatic t_repeat;
    int n;
    @(negedge clk);
    srcMode = 2'h3;
    wait_on(4, 600, n);
    chk(repeatCount, 16'h0000);
    hold_no_words(2'h0);
    chk(repeatFailFlag, 1'b1);
    $display("test repeat end");
  endtask

  task automatic t_online_run;
    int n;
    @(negedge clk);
    srcMode = 2'h2;
    wait_on(3, 21000, n);
    hold_no_words(2'h0);
    chk(onlineFailFlag, 1'b1);
    $display("test online end");
  endtask

  // main sequence
  initial begin
    t_startup(2'h0);
    t_words8;
    t_words16;
    t_stuck;
    t_startup(2'h2);
    t_startup(2'h0);
    t_repeat;
    t_startup(2'h0);
    t_online_run;
    give_verdict;
  end
endmodule
`default_nettype wire
